// ---- ssid_top.sv ----
// Functional notes
// - opcode B9h is recognised as a sleep request
// - sleep entry starts only when chip select rises after the seventh opcode bit
// - after decode at seventh clock, clock and data ignored until release
// - stays asleep while chip select is high
// - falling chip select while asleep starts wake-up
// - wake-up done and commands accepted within 100 us of falling select
// - identification read shifts out maker byte then two device bytes
// - sample input on rising clock, drive output on falling clock
// - undefined opcode deselects for rest of the select cycle
// top of sleep and identification command logic
// assumes sclk only runs with chip select low; serial data driven by host
`timescale 1ns/100ps
`default_nettype none
module ssid_top
#(
	parameter int RECOVERY_CYCLES = ssid_pkg::SSID_RECOVERY_CYCLES
)
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic sclk,
	input wire logic selectN,
	input wire logic serIn,
	output logic serOut,
	output logic serOutEn,
	output logic asleep,
	output logic ready
);
	import ssid_pkg::*;
	logic selectHighSync, sleepTogSync, linkSerOut, linkSerOutEn, sleepReqTog;
	ssid_power_type power_ff, nxt_power;
	logic [31:0] recCnt_ff, nxt_recCnt;
	logic [7:0] puCnt_ff, nxt_puCnt;
	logic puDone_ff, nxt_puDone;
	logic selPrev_ff, nxt_selPrev;
	logic sleepTogPrev_ff, nxt_sleepTogPrev;
	logic linkEn_ff, nxt_linkEn;
	logic asleep_ff, nxt_asleep;
	logic ready_ff, nxt_ready;
	logic serOutEn_ff, nxt_serOutEn;
	logic serOut_ff, nxt_serOut;
	logic linkOutSync, linkOutEnSync;
	ssid_sync #(.RESET_VALUE(1'b1)) uSelSync (.core_clk(core_clk), .rst_b(rst_b),
		.asyncIn(selectN), .syncOut(selectHighSync));
	ssid_sync #(.RESET_VALUE(1'b0)) uTogSync (.core_clk(core_clk), .rst_b(rst_b),
		.asyncIn(sleepReqTog), .syncOut(sleepTogSync));
	ssid_sync #(.RESET_VALUE(1'b0)) uOutSync (.core_clk(core_clk), .rst_b(rst_b),
		.asyncIn(linkSerOut), .syncOut(linkOutSync));
	ssid_sync #(.RESET_VALUE(1'b0)) uOenSync (.core_clk(core_clk), .rst_b(rst_b),
		.asyncIn(linkSerOutEn), .syncOut(linkOutEnSync));
	// enable is quasi-static: it only moves while select is high and sclk is stopped;
	// a synchroniser clocked by sclk would lag two bits into every frame, so none is used
	// limitation: host must give select about four core cycles before the first sclk rise
	ssid_link uLink (.sclk(sclk), .rst_b(rst_b), .csHigh(selectN), .serIn(serIn),
		.linkEnable(linkEn_ff), .sleepReqTog(sleepReqTog), .serOut(linkSerOut),
		.serOutEn(linkSerOutEn));
	// power state: awake, asleep, waking with recovery countdown
	always_comb
	begin
		nxt_power = power_ff;
		nxt_recCnt = recCnt_ff;
		nxt_puCnt = puCnt_ff;
		nxt_puDone = puDone_ff;
		nxt_selPrev = selectHighSync;
		nxt_sleepTogPrev = sleepTogSync;
		// host must keep select high this long after power-up
		if (!puDone_ff)
		begin
			if (!selectHighSync)
				nxt_puCnt = 8'h00;
			else if (puCnt_ff == 8'(SSID_POWERUP_CYCLES - 1))
				nxt_puDone = 1'b1;
			else
				nxt_puCnt = puCnt_ff + 8'h01;
		end
		unique case (power_ff)
			SSID_AWAKE:
			begin
				if (sleepTogSync != sleepTogPrev_ff)
					nxt_power = SSID_ASLEEP; // committed at select rise
			end
			SSID_ASLEEP:
			begin
				// high select holds sleep regardless of other pins
				if (selPrev_ff && !selectHighSync)
				begin
					nxt_power = SSID_WAKING; // falling select wakes
					nxt_recCnt = 32'h0;
				end
			end
			SSID_WAKING:
			begin
				// bounded recovery; synchroniser delay included in count
				if (recCnt_ff >= 32'(RECOVERY_CYCLES - 4))
					nxt_power = SSID_AWAKE;
				else
					nxt_recCnt = recCnt_ff + 32'h1;
			end
		endcase
	end
	// status and gated output; link enable only moves while select high
	always_comb
	begin
		nxt_asleep = (nxt_power != SSID_AWAKE);
		nxt_ready = (nxt_power == SSID_AWAKE) && puDone_ff;
		nxt_linkEn = linkEn_ff;
		if (selectHighSync)
			nxt_linkEn = (nxt_power == SSID_AWAKE) && puDone_ff; // commands ignored
		// a dummy read during waking sees high impedance until awake
		nxt_serOutEn = linkOutEnSync && (power_ff == SSID_AWAKE); // high impedance
		nxt_serOut = linkOutSync;
	end
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			power_ff <= SSID_AWAKE;
			recCnt_ff <= 32'h0;
			puCnt_ff <= 8'h00;
			puDone_ff <= 1'b0;
			selPrev_ff <= 1'b1;
			sleepTogPrev_ff <= 1'b0;
			linkEn_ff <= 1'b0;
			asleep_ff <= 1'b0;
			ready_ff <= 1'b0;
			serOutEn_ff <= 1'b0;
			serOut_ff <= 1'b0;
		end
		else
		begin
			power_ff <= nxt_power;
			recCnt_ff <= nxt_recCnt;
			puCnt_ff <= nxt_puCnt;
			puDone_ff <= nxt_puDone;
			selPrev_ff <= nxt_selPrev;
			sleepTogPrev_ff <= nxt_sleepTogPrev;
			linkEn_ff <= nxt_linkEn;
			asleep_ff <= nxt_asleep;
			ready_ff <= nxt_ready;
			serOutEn_ff <= nxt_serOutEn;
			serOut_ff <= nxt_serOut;
		end
	end
	assign asleep = asleep_ff;
	assign ready = ready_ff;
	assign serOutEn = serOutEn_ff;
	assign serOut = serOut_ff;
endmodule
`default_nettype wire

// ---- ssid_pkg.sv ----
// package for the serial sleep and identification command logic
// assumes a 125 MHz core clock and a serial-clock-driven link domain
package ssid_pkg;
	localparam logic [7:0] SSID_OP_SLEEP = 8'hB9;
	localparam logic [7:0] SSID_OP_READ_ID = 8'h9F;
	localparam logic [7:0] SSID_MAKER_CODE = 8'h5A; // arbitrary
	localparam logic [15:0] SSID_DEVICE_CODE = 16'hC3A5; // arbitrary
	localparam int SSID_CORE_CLK_MHZ = 125;
	localparam int SSID_SLEEP_RECOVERY_TIME_US = 100;
	localparam int SSID_RECOVERY_CYCLES = SSID_SLEEP_RECOVERY_TIME_US * SSID_CORE_CLK_MHZ;
	localparam int SSID_POWERUP_SELECT_HIGH_HOLD_NS = 100;
	localparam int SSID_POWERUP_CYCLES = (SSID_POWERUP_SELECT_HIGH_HOLD_NS * SSID_CORE_CLK_MHZ
		+ 999) / 1000;
	localparam int SSID_ID_BITS = 24;
	localparam logic [2:0] SSID_OPCODE_LAST_BIT = 3'h7;
	localparam logic [2:0] SSID_DECODE_BIT = 3'h6;
	typedef enum logic [1:0] {SSID_AWAKE, SSID_ASLEEP, SSID_WAKING} ssid_power_type;
endpackage

// ---- ssid_sync.sv ----
// two flip-flop level synchroniser
// assumes the input is a level from another domain
`timescale 1ns/100ps
`default_nettype none
module ssid_sync
#(
	parameter logic RESET_VALUE = 1'b0
)
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic asyncIn,
	output logic syncOut
);
	logic stage1_ff;
	logic stage2_ff;
	// first stage is read by the second stage only
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stage1_ff <= RESET_VALUE;
			stage2_ff <= RESET_VALUE;
		end
		else
		begin
			stage1_ff <= asyncIn;
			stage2_ff <= stage1_ff;
		end
	end
	assign syncOut = stage2_ff;
endmodule
`default_nettype wire

// ---- ssid_link.sv ----
// serial-clock side: opcode shifter, decode and identification shift-out
// assumes the serial clock only toggles while chip select is low
`timescale 1ns/100ps
`default_nettype none
module ssid_link
(
	input wire logic sclk,
	input wire logic rst_b,
	input wire logic csHigh,
	input wire logic serIn,
	input wire logic linkEnable,
	output logic sleepReqTog,
	output logic serOut,
	output logic serOutEn
);
	import ssid_pkg::*;
	logic [2:0] bitCnt_ff, nxt_bitCnt;
	logic [6:0] shift_ff, nxt_shift;
	logic opDone_ff, nxt_opDone;
	logic idMode_ff, nxt_idMode;
	logic sleepSeen_ff, nxt_sleepSeen;
	logic [4:0] idIdx_ff, nxt_idIdx;
	logic sleepTog_ff, nxt_sleepTog;
	logic serOut_ff, nxt_serOut;
	logic serOutEn_ff, nxt_serOutEn;
	logic [7:0] opByte;
	logic [SSID_ID_BITS-1:0] idWord;
	assign idWord = {SSID_MAKER_CODE, SSID_DEVICE_CODE}; // maker first
	assign opByte = {shift_ff, serIn}; // msb first
	// rising edge sampling of the command byte
	always_comb
	begin
		nxt_bitCnt = bitCnt_ff;
		nxt_shift = shift_ff;
		nxt_opDone = opDone_ff;
		nxt_idMode = idMode_ff;
		nxt_sleepSeen = sleepSeen_ff;
		if (!opDone_ff && linkEnable) // asleep or waking: commands ignored
		begin
			nxt_shift = opByte[6:0]; // sample on rising edge
			nxt_bitCnt = bitCnt_ff + 3'h1;
			if (bitCnt_ff == SSID_DECODE_BIT && opByte[6:0] == SSID_OP_SLEEP[7:1])
			begin
				nxt_opDone = 1'b1; // later clocks ignored after seventh count
				nxt_sleepSeen = 1'b1;
			end
			if (bitCnt_ff == SSID_OPCODE_LAST_BIT)
			begin
				nxt_opDone = 1'b1; // unknown opcode deselects until release
				nxt_idMode = (opByte == SSID_OP_READ_ID);
			end
		end
	end
	// chip select high clears the command state without a clock edge
	always_ff @(posedge sclk or posedge csHigh)
	begin
		if (csHigh)
		begin
			bitCnt_ff <= 3'h0;
			shift_ff <= 7'h00;
			opDone_ff <= 1'b0;
			idMode_ff <= 1'b0;
			sleepSeen_ff <= 1'b0;
		end
		else
		begin
			bitCnt_ff <= nxt_bitCnt;
			shift_ff <= nxt_shift;
			opDone_ff <= nxt_opDone;
			idMode_ff <= nxt_idMode;
			sleepSeen_ff <= nxt_sleepSeen;
		end
	end
	// a completed sleep opcode is committed when chip select rises
	always_comb
	begin
		nxt_sleepTog = sleepTog_ff ^ sleepSeen_ff; // sleep opcode recognised
	end
	// needs a reset of its own: an unknown toggle would never compare in the core domain
	always_ff @(posedge csHigh or negedge rst_b)
	begin
		if (!rst_b)
			sleepTog_ff <= 1'b0;
		else
			sleepTog_ff <= nxt_sleepTog;
	end
	assign sleepReqTog = sleepTog_ff;
	// falling edge drive of identification bits
	always_comb
	begin
		nxt_idIdx = idIdx_ff;
		nxt_serOut = serOut_ff;
		nxt_serOutEn = 1'b0;
		if (idMode_ff)
		begin
			nxt_serOutEn = 1'b1;
			nxt_serOut = idWord[5'(SSID_ID_BITS - 1) - idIdx_ff]; // three bytes
			nxt_idIdx = (idIdx_ff == 5'(SSID_ID_BITS - 1)) ? 5'h00 : idIdx_ff + 5'h01;
		end
	end
	always_ff @(negedge sclk or posedge csHigh)
	begin
		if (csHigh)
		begin
			idIdx_ff <= 5'h00;
			serOut_ff <= 1'b0;
			serOutEn_ff <= 1'b0;
		end
		else
		begin
			idIdx_ff <= nxt_idIdx;
			serOut_ff <= nxt_serOut;
			serOutEn_ff <= nxt_serOutEn;
		end
	end
	assign serOut = serOut_ff;
	assign serOutEn = serOutEn_ff;
endmodule
`default_nettype wire

// ---- ssid_sva.sv ----
// checker for the sleep and identification logic
// assumes it is bound to ssid_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module ssid_sva
#(
	parameter int RECOVERY_CYCLES = 40
)
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic sclk,
	input wire logic selectN,
	input wire logic serIn,
	input wire logic serOut,
	input wire logic serOutEn,
	input wire logic asleep,
	input wire logic ready
);
	// slack covers the select synchroniser on top of the countdown
	localparam int WAKE_MAX = RECOVERY_CYCLES + 20;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	// select falling while asleep starts the wake-up
	sequence wakeStart;
		asleep && $fell(selectN);
	endsequence
	chk_sleep_quiet: assert property (asleep |-> !serOutEn) else $error("drive asleep");
	chk_sleep_busy: assert property (asleep |-> !ready) else $error("ready asleep");
	chk_entry_release: assert property ($rose(asleep) |-> $past(selectN, 3))
		else $error("early sleep");
	chk_stay_asleep: assert property ($rose(asleep) |=> asleep[*8]) else $error("woke");
	chk_wake_bound: assert property (wakeStart |-> ##[1:WAKE_MAX] !asleep)
		else $error("wake late");
	chk_wake_min: assert property ($fell(asleep) |-> $past(asleep, 30))
		else $error("wake early");
	chk_ready_after: assert property ($fell(asleep) |-> ##[0:2] ready)
		else $error("not ready");
	chk_idle_quiet: assert property (selectN[*8] |-> !serOutEn)
		else $error("drive idle");
endmodule
bind ssid_top ssid_sva #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) uSva (.core_clk(core_clk),
	.rst_b(rst_b), .sclk(sclk), .selectN(selectN), .serIn(serIn), .serOut(serOut),
	.serOutEn(serOutEn), .asleep(asleep), .ready(ready));
`default_nettype wire

// ---- ssid_host.sv ----
// host model: drives select, serial clock and data, samples output
// assumes the device samples on clock rise and drives on clock fall
`timescale 1ns/100ps
`default_nettype none
module ssid_host
(
	output logic sclk,
	output logic selectN,
	output logic serIn,
	input wire logic serOut,
	input wire logic serOutEn
);
	// select high from power-up, clock idle low
	initial
	begin
		sclk = 1'b0;
		selectN = 1'b1;
		serIn = 1'b0;
	end
	// one frame, 125 ns clock only inside it; output sampled late in low phase
	task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx,
		output logic drv);
		rx = 32'h0;
		drv = 1'b0;
		selectN = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			serIn = tx[n - 1 - i];
			#62.5;
			// a released pin has no pull: show the inverse of the last value
			rx = {rx[30:0], serOutEn ? serOut : ~serOut};
			drv = drv | serOutEn;
			sclk = 1'b1;
			#62.5;
			sclk = 1'b0;
		end
		#62.5;
		selectN = 1'b1;
		serIn = ~serIn;
		#300;
	endtask
endmodule
`default_nettype wire

// ---- ssid_top_tb.sv ----
// self-checking bench for the sleep and identification logic
// assumes ssid_host as the serial host and the bound checker
`timescale 1ns/100ps
`default_nettype none
module ssid_top_tb;
	import ssid_pkg::*;
	logic core_clk, rst_b, sclk, selectN, serIn, serOut, serOutEn, asleep, ready, drv;
	logic [31:0] rx;
	int fails;
	int check_count;
	// short recovery count keeps the run brief
	ssid_top #(.RECOVERY_CYCLES(40)) dut (.core_clk(core_clk), .rst_b(rst_b), .sclk(sclk),
		.selectN(selectN), .serIn(serIn), .serOut(serOut), .serOutEn(serOutEn),
		.asleep(asleep), .ready(ready));
	ssid_host host (.sclk(sclk), .selectN(selectN), .serIn(serIn), .serOut(serOut),
		.serOutEn(serOutEn));
	// 125 MHz core clock
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (fails == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// bounded wait for ready
	task automatic wait_ready();
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 200)
		begin
			@(negedge core_clk);
			n++;
		end
		cmp({30'h0, asleep, ready}, 32'h1);
	endtask
	task automatic t_id();
		host.xfer({SSID_OP_READ_ID, 24'h0}, 32, rx, drv);
		cmp({8'h0, rx[23:0]}, {8'h0, SSID_MAKER_CODE, SSID_DEVICE_CODE});
		cmp({31'h0, drv}, 32'h1);
	endtask
	task automatic t_bad();
		host.xfer(32'h03FFFFFF, 32, rx, drv);
		cmp({31'h0, drv}, 32'h0);
	endtask
	// sleep with an id opcode clocked after it, hold, then wake by a dummy read
	task automatic t_sleep();
		host.xfer({SSID_OP_SLEEP, SSID_OP_READ_ID, 16'h0}, 32, rx, drv);
		cmp({31'h0, drv}, 32'h0);
		cmp({30'h0, asleep, ready}, 32'h2);
		repeat (100) @(negedge core_clk);
		cmp({30'h0, asleep, ready}, 32'h2);
		host.xfer({16'h0, SSID_OP_READ_ID, 8'h0}, 16, rx, drv);
		cmp({31'h0, drv}, 32'h0);
		wait_ready();
		t_id();
	endtask
	initial
	begin
		fails = 0;
		check_count = 0;
		rst_b = 1'b0;
		repeat (5) @(negedge core_clk);
		rst_b = 1'b1;
		wait_ready();
		t_id();
		t_bad();
		t_id();
		t_sleep();
		report_and_stop();
	end
	// watchdog, far beyond the few frames above
	initial
	begin
		#400000;
		fails++;
		report_and_stop();
	end
endmodule
`default_nettype wire
